/* File: rtl/amp_diag_defines.svh */
// named constants for the amplifier control and diagnostic block
// assumes inclusion by its bare name from package and modules
`ifndef AMP_DIAG_DEFINES_SVH
`define AMP_DIAG_DEFINES_SVH
`define SLAVE_ADDR 7'h6c
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define FIRST_CNT 4'h1
`define WR_BYTES 2'h2
`define BIT_RESET 1'h0
`define BYTE_RESET 8'h00
`define CH_W 6
`define CH_FAULT_W 24
`define FAULT_W 25
`define THERMAL_IDX 24
`define CLK_HZ 10_000_000
`define DIAG_CYCLE_MS 100
`define C1_DIAG_EN 6
`define C1_OFFSET_EN 5
`define C1_GAIN_FRONT 4
`define C1_GAIN_REAR 3
`define C1_UNMUTE_FRONT 2
`define C1_UNMUTE_REAR 1
`define C1_CLIP 0
`define C2_TEST_HI 6
`define C2_TEST_LO 5
`define C2_OPERATE 4
`define C2_LINE_DRV 3
`define C2_CUR_DET 2
`define C2_HIEFF_RIGHT 1
`define C2_HIEFF_LEFT 0
`endif

/* File: rtl/amp_diag_pkg.sv */
// types shared by the amplifier control and diagnostic block
// assumes the defines header is on the include path
`include "amp_diag_defines.svh"
package amp_diag_pkg;
  typedef enum logic [1:0] {
    LS_IDLE = 2'h0,
    LS_ADDR = 2'h1,
    LS_WRITE = 2'h2,
    LS_READ = 2'h3
  } link_state_e;
  typedef logic [7:0] byte_t;
  typedef logic [`CH_FAULT_W-1:0] chan_fault_t;
  typedef logic [`FAULT_W-1:0] fault_t;
endpackage : amp_diag_pkg

/* File: rtl/diag_if.sv */
// carrier between the control top and the fault persistence filter
// assumes both ends run on the system clock
`timescale 1ns/10ps
interface diag_if;
  import amp_diag_pkg::*;
  logic restart;
  logic enable;
  fault_t sample;
  fault_t result;
  logic done_res;
  modport ctl (output restart, output enable, output sample, input result, input done_res);
  modport flt (input restart, input enable, input sample, output result, output done_res);
endinterface : diag_if

/* File: rtl/diag_filter.sv */
// fault persistence filter: a fault is kept only if steady over a whole cycle
// assumes synchronised samples and a one-cycle restart pulse on i_clk
`timescale 1ns/10ps
`include "amp_diag_defines.svh"
module diag_filter #(
  parameter int unsigned CYCLE_CYC = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  diag_if.flt d
);
  import amp_diag_pkg::*;

  logic [31:0] cyc_cnt;
  fault_t persist;
  logic done_res;
  wire cyc_full = cyc_cnt >= CYCLE_CYC;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cyc_cnt <= 32'h0000_0000;
    end else if (d.restart) begin
      cyc_cnt <= 32'h0000_0000;
    end else if (d.enable && !cyc_full) begin
      cyc_cnt <= cyc_cnt + 32'h0000_0001;
    end
  end

  // each restart opens a fresh interval and hands over the closing one
  genvar gi;
  generate
    for (gi = 0; gi < `FAULT_W; gi++) begin : g_bit
      logic keep;
      logic res;
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          keep <= 1'b1;
          res <= 1'b0;
        end else if (d.restart) begin
          keep <= 1'b1;
          res <= keep;
        end else begin
          keep <= keep & d.sample[gi];
        end
      end
      assign persist[gi] = keep;
      assign d.result[gi] = res;
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_res <= 1'b0;
    end else if (d.restart) begin
      done_res <= cyc_full & d.enable;
    end
  end
  assign d.done_res = done_res;

  AST_RESULT_FROM_PAST: assert property (@(posedge i_clk) disable iff (i_rst)
    d.restart |=> d.result == $past(persist))
    else $error("result not taken from closing interval");
  AST_GAP_DROPS_FAULT: assert property (@(posedge i_clk) disable iff (i_rst)
    (!d.restart && !d.sample[0]) |=> !persist[0])
    else $error("interrupted fault still reported");
  AST_SHORT_CYCLE_NOT_DONE: assert property (@(posedge i_clk) disable iff (i_rst)
    (d.restart && !cyc_full) |=> !d.done_res)
    else $error("cycle reported done too early");
  CVR_FAULT_REPORTED: cover property (@(posedge i_clk) disable iff (i_rst)
    d.restart ##1 d.result[0]);
  CVR_CYCLE_DONE: cover property (@(posedge i_clk) disable iff (i_rst)
    d.restart ##1 d.done_res);
endmodule : diag_filter

/* File: rtl/amp_i2c_control_diag.sv */
// two-wire slave for a quad amplifier: two control bytes in, four status bytes out
// assumes scl and sda arrive as separate input and open-drain enable; link logic on scl
// How it works
// - a fault is reported only if present through the whole interval
// - each read restarts every diagnostic cycle type
// - a read returns results latched by the previous restart
// - sda changes while scl low; start and stop are sda edges, scl high
// - bytes are 8 bits, msb first, then one acknowledge clock
// - transmitter releases sda at acknowledge; receiver pulls it low
// - address byte d8 hex with bit 0 selecting write or read
// - a write carries exactly two control bytes in order
// - a read returns the four status bytes in order
// - control one: diagnostics enable and offset detection enable bits
// - control one: front and rear gain select, 0 gives 26dB, 1 gives 12dB
// - control one: per pair unmute bits and clip threshold select
// - control two: operate, line driver thresholds, current detection enable
// - control two: right and left high-efficiency bits, test bits
// - status one holds thermal warning and cycle terminated flag
// - each channel field: current, mode, short load, open, vcc, ground
// - status two holds offset active, current sensor active, left rear
// - status three mirrors operate and diagnostics; status four right rear
`timescale 1ns/10ps
`include "amp_diag_defines.svh"
module amp_i2c_control_diag #(
  parameter int unsigned DIAG_CYCLE_CYC = `DIAG_CYCLE_MS * (`CLK_HZ / 1000)
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_thermal_warn,
  input wire amp_diag_pkg::chan_fault_t i_ch_fault,
  output logic o_diag_en,
  output logic o_offset_en,
  output logic o_gain_front_low,
  output logic o_gain_rear_low,
  output logic o_unmute_front,
  output logic o_unmute_rear,
  output logic o_clip_high,
  output logic o_test_hi,
  output logic o_test_lo,
  output logic o_operate,
  output logic o_line_driver,
  output logic o_current_det_en,
  output logic o_hieff_right,
  output logic o_hieff_left,
  output logic o_diag_restart
);
  import amp_diag_pkg::*;

  // link side, clocked by scl or by sda edges
  logic start_tog;
  logic stop_tog;
  logic start_seen;
  logic stop_seen;
  link_state_e state;
  link_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  byte_t shift;
  byte_t next_shift;
  logic [1:0] byte_idx;
  logic [1:0] next_idx;
  byte_t stage_one;
  byte_t stage_two;
  logic wr_tog;
  logic rd_tog;

  // system side
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  fault_t fault_meta;
  fault_t fault_sync;
  byte_t status_byte [4];

  diag_if dif ();

  // start and stop flip a toggle; the scl side sees the change at its next edge.
  // the toggles are stable over the whole scl low phase before that edge.
  always_ff @(negedge i_sda or posedge i_rst) begin
    if (i_rst) begin
      start_tog <= `BIT_RESET;
    end else if (i_scl) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge i_sda or posedge i_rst) begin
    if (i_rst) begin
      stop_tog <= `BIT_RESET;
    end else if (i_scl) begin
      stop_tog <= ~stop_tog;
    end
  end

  wire new_start = start_tog ^ start_seen;
  wire new_stop = stop_tog ^ stop_seen;
  wire link_step = !new_start && !new_stop;
  wire byte_end = bit_cnt == `BYTE_BITS;
  wire addr_hit = shift[7:1] == `SLAVE_ADDR;
  wire read_req = shift[0];
  wire host_ack = ~i_sda;
  wire [7:0] rx_byte = {shift[6:0], i_sda};
  wire [2:0] bit_sel = 3'(`LAST_BIT - bit_cnt);
  wire [7:0] tx_byte = status_byte[byte_idx];

  wire wr_done = link_step && state == LS_WRITE && byte_end;
  wire take_one = wr_done && byte_idx == 2'h0;
  wire take_two = wr_done && byte_idx == 2'h1;
  wire rd_done = link_step && state == LS_READ && byte_end && !host_ack;

  // sda is the data of this domain: sampled on rising scl, driven on falling scl
  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_shift = shift;
    next_idx = byte_idx;
    if (new_start) begin
      next_state = LS_ADDR;
      next_cnt = `FIRST_CNT;
      next_shift = {7'h00, i_sda};
      next_idx = 2'h0;
    end else if (new_stop) begin
      next_state = LS_IDLE;
    end else begin
      unique case (state)
        LS_IDLE: begin
          next_state = LS_IDLE;
        end
        LS_ADDR: begin
          if (!byte_end) begin
            next_shift = rx_byte;
            next_cnt = bit_cnt + 4'h1;
          end else begin
            next_cnt = 4'h0;
            if (!addr_hit) begin
              next_state = LS_IDLE;
            end else if (read_req) begin
              next_state = LS_READ;
            end else begin
              next_state = LS_WRITE;
            end
          end
        end
        LS_WRITE: begin
          if (!byte_end) begin
            next_shift = rx_byte;
            next_cnt = bit_cnt + 4'h1;
          end else begin
            next_cnt = 4'h0;
            // index parks at two so later bytes fall on the floor
            if (byte_idx != `WR_BYTES) begin
              next_idx = byte_idx + 2'h1;
            end
          end
        end
        LS_READ: begin
          if (!byte_end) begin
            next_cnt = bit_cnt + 4'h1;
          end else begin
            next_cnt = 4'h0;
            if (host_ack) begin
              next_idx = byte_idx + 2'h1;
            end else begin
              next_state = LS_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      start_seen <= `BIT_RESET;
      stop_seen <= `BIT_RESET;
      state <= LS_IDLE;
      bit_cnt <= 4'h0;
      shift <= `BYTE_RESET;
      byte_idx <= 2'h0;
    end else begin
      start_seen <= start_tog;
      stop_seen <= stop_tog;
      state <= next_state;
      bit_cnt <= next_cnt;
      shift <= next_shift;
      byte_idx <= next_idx;
    end
  end

  // control bytes wait in stages; the toggle tells the system side to copy both
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      stage_one <= `BYTE_RESET;
      stage_two <= `BYTE_RESET;
      wr_tog <= `BIT_RESET;
      rd_tog <= `BIT_RESET;
    end else begin
      if (take_one) begin
        stage_one <= shift;
      end
      if (take_two) begin
        stage_two <= shift;
        wr_tog <= ~wr_tog;
      end
      // restart is raised when the host ends the read, so the bytes being
      // shifted out can never change under it
      if (rd_done) begin
        rd_tog <= ~rd_tog;
      end
    end
  end

  wire ack_addr = state == LS_ADDR && byte_end && addr_hit && link_step;
  wire ack_wr = state == LS_WRITE && byte_end && link_step;
  wire drive_rd = state == LS_READ && !byte_end && link_step && !tx_byte[bit_sel];
  wire next_oe = ack_addr | ack_wr | drive_rd;

  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      o_sda_oe <= `BIT_RESET;
    end else begin
      o_sda_oe <= next_oe;
    end
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out <= `BIT_RESET;
    end else begin
      o_sda_out <= `BIT_RESET;
    end
  end

  // crossings: toggles through two flops, third flop only for the edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
      fault_meta <= '0;
      fault_sync <= '0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tog};
      rd_sync <= {rd_sync[1:0], rd_tog};
      fault_meta <= {i_thermal_warn, i_ch_fault};
      fault_sync <= fault_meta;
    end
  end

  wire wr_evt = wr_sync[2] ^ wr_sync[1];
  wire rd_evt = rd_sync[2] ^ rd_sync[1];

  // stages are quiet here: the next write needs many more scl cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_diag_en <= `BIT_RESET;
      o_offset_en <= `BIT_RESET;
      o_gain_front_low <= `BIT_RESET;
      o_gain_rear_low <= `BIT_RESET;
      o_unmute_front <= `BIT_RESET;
      o_unmute_rear <= `BIT_RESET;
      o_clip_high <= `BIT_RESET;
    end else if (wr_evt) begin
      o_diag_en <= stage_one[`C1_DIAG_EN];
      o_offset_en <= stage_one[`C1_OFFSET_EN];
      o_gain_front_low <= stage_one[`C1_GAIN_FRONT];
      o_gain_rear_low <= stage_one[`C1_GAIN_REAR];
      o_unmute_front <= stage_one[`C1_UNMUTE_FRONT];
      o_unmute_rear <= stage_one[`C1_UNMUTE_REAR];
      o_clip_high <= stage_one[`C1_CLIP];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_test_hi <= `BIT_RESET;
      o_test_lo <= `BIT_RESET;
      o_operate <= `BIT_RESET;
      o_line_driver <= `BIT_RESET;
      o_current_det_en <= `BIT_RESET;
      o_hieff_right <= `BIT_RESET;
      o_hieff_left <= `BIT_RESET;
    end else if (wr_evt) begin
      o_test_hi <= stage_two[`C2_TEST_HI];
      o_test_lo <= stage_two[`C2_TEST_LO];
      o_operate <= stage_two[`C2_OPERATE];
      o_line_driver <= stage_two[`C2_LINE_DRV];
      o_current_det_en <= stage_two[`C2_CUR_DET];
      o_hieff_right <= stage_two[`C2_HIEFF_RIGHT];
      o_hieff_left <= stage_two[`C2_HIEFF_LEFT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_diag_restart <= `BIT_RESET;
    end else begin
      o_diag_restart <= rd_evt;
    end
  end

  assign dif.restart = o_diag_restart;
  assign dif.enable = o_diag_en;
  assign dif.sample = fault_sync;

  diag_filter #(
    .CYCLE_CYC(DIAG_CYCLE_CYC)
  ) u_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .d(dif.flt)
  );

  // status bytes change only at a restart or write, both away from a read
  assign status_byte[0] = {dif.result[`THERMAL_IDX], dif.done_res, dif.result[0 +: `CH_W]};
  assign status_byte[1] = {o_offset_en, o_current_det_en, dif.result[`CH_W +: `CH_W]};
  assign status_byte[2] = {o_operate, o_diag_en, dif.result[2*`CH_W +: `CH_W]};
  assign status_byte[3] = {2'h0, dif.result[3*`CH_W +: `CH_W]};

  AST_FOREIGN_ADDR_IDLE: assert property (@(posedge i_scl) disable iff (i_rst)
    (link_step && state == LS_ADDR && byte_end && !addr_hit) |=> state == LS_IDLE)
    else $error("foreign address not ignored");
  AST_OWN_ADDR_ACKED: assert property (@(posedge i_scl) disable iff (i_rst)
    (state == LS_ADDR && byte_end && addr_hit && link_step) |-> o_sda_oe)
    else $error("own address not acknowledged");
  AST_WRITE_ACKED: assert property (@(posedge i_scl) disable iff (i_rst)
    (state == LS_WRITE && byte_end && link_step) |-> o_sda_oe)
    else $error("written byte not acknowledged");
  AST_READ_NEXT_BYTE: assert property (@(posedge i_scl) disable iff (i_rst)
    (link_step && state == LS_READ && byte_end && host_ack) |=> byte_idx == 2'($past(byte_idx) + 2'h1))
    else $error("status byte order broken");
  AST_NACK_ENDS_READ: assert property (@(posedge i_scl) disable iff (i_rst)
    rd_done |=> state == LS_IDLE && !o_sda_oe)
    else $error("read not ended on missing ack");
  AST_WRITE_IDX_PARKS: assert property (@(posedge i_scl) disable iff (i_rst)
    (wr_done && byte_idx == `WR_BYTES) |=> byte_idx == `WR_BYTES)
    else $error("extra write byte not ignored");
  AST_CTRL_ONE_APPLIED: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_evt |=> o_diag_en == $past(stage_one[`C1_DIAG_EN]) && o_offset_en == $past(stage_one[`C1_OFFSET_EN]))
    else $error("control one enables not applied");
  AST_GAIN_MUTE_APPLIED: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_evt |=> {o_gain_front_low, o_gain_rear_low, o_unmute_front} == $past(stage_one[4:2]))
    else $error("gain or mute not applied");
  AST_CTRL_TWO_APPLIED: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_evt |=> {o_operate, o_line_driver, o_current_det_en} == $past(stage_two[4:2]))
    else $error("control two not applied");
  AST_READ_RESTARTS: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_evt |=> o_diag_restart ##1 !o_diag_restart)
    else $error("read did not restart diagnostics");
  CVR_WRITE_DONE: cover property (@(posedge i_clk) disable iff (i_rst) wr_evt);
  CVR_READ_DONE: cover property (@(posedge i_clk) disable iff (i_rst) rd_evt);
  CVR_FOURTH_BYTE: cover property (@(posedge i_scl) disable iff (i_rst)
    state == LS_READ && byte_idx == 2'h3 && byte_end);
endmodule : amp_i2c_control_diag

/* File: tb/amp_host_model.sv */
// two-wire bus host model: start, byte, acknowledge and stop cycles
// assumes the bench resolves the data wire with a pull-up from all enables
`timescale 1ns/10ps
module amp_host_model (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  import amp_diag_pkg::*;
  // bus clock runs only inside frames and idles high between them
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start_cond;
    o_sda_oe = 1'b0;
    o_scl = 1'b1;
    #15 o_sda_oe = 1'b1;
    #15 o_scl = 1'b0;
  endtask : start_cond
  // one 30 ns clock; data moves only in the low half, sampled 7 ns into the 15 ns high half
  task automatic bit_cyc(input logic b, output logic s);
    #7 o_sda_oe = ~b;
    #8 o_scl = 1'b1;
    #7 s = i_sda;
    #8 o_scl = 1'b0;
  endtask : bit_cyc
  task automatic send_byte(input byte_t b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
    bit_cyc(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic recv_byte(input logic ack, output byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, s);
      b[i] = s;
    end
    bit_cyc(~ack, s);
  endtask : recv_byte
  task automatic stop_cond;
    #7 o_sda_oe = 1'b1;
    #8 o_scl = 1'b1;
    #15 o_sda_oe = 1'b0;
  endtask : stop_cond
endmodule : amp_host_model

/* File: tb/amp_i2c_control_diag_tb.sv */
// self-checking bench: control writes, foreign addresses, status reads and restarts
// assumes the host model drives the bus; fault inputs are driven on the system clock
`timescale 1ns/10ps
`include "amp_diag_defines.svh"
module amp_i2c_control_diag_tb;
  import amp_diag_pkg::*;
  localparam int unsigned CYC = 20;
  logic i_clk = 1'b0;
  logic i_rst;
  logic scl, host_oe, sda_oe, sda_out, restart, ack, thermal;
  logic [6:0] ctl1, ctl2;
  chan_fault_t fault, f0, f2, m;
  byte_t c1, c2, app1, app2, q, a;
  integer seed = 2;
  int err_count = 0;
  int n_checks = 0;
  int n_rst = 0;
  int exp_rst = 0;
  wire sda = (host_oe | sda_oe) ? 1'b0 : 1'b1;

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (restart === 1'b1) n_rst <= n_rst + 1;

  amp_host_model u_amp_host_model (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));
  amp_i2c_control_diag #(.DIAG_CYCLE_CYC(CYC)) u_amp_i2c_control_diag (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_thermal_warn(thermal), .i_ch_fault(fault), .o_diag_en(ctl1[6]), .o_offset_en(ctl1[5]),
    .o_gain_front_low(ctl1[4]), .o_gain_rear_low(ctl1[3]), .o_unmute_front(ctl1[2]),
    .o_unmute_rear(ctl1[1]), .o_clip_high(ctl1[0]), .o_test_hi(ctl2[6]), .o_test_lo(ctl2[5]),
    .o_operate(ctl2[4]), .o_line_driver(ctl2[3]), .o_current_det_en(ctl2[2]),
    .o_hieff_right(ctl2[1]), .o_hieff_left(ctl2[0]), .o_diag_restart(restart));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] exp_status(input logic th, input logic done, input chan_fault_t f);
    return {th, done, f[5:0], app1[5], app2[2], f[11:6], app2[4], app1[6], f[17:12], 2'h0, f[23:18]};
  endfunction : exp_status

  task automatic gap(input int n);
    repeat (n) @(posedge i_clk);
  endtask : gap

  // n data bytes: control one, control two, then a surplus byte
  task automatic wr(input byte_t addr, input int n);
    logic hit;
    byte_t b;
    hit = (addr[7:1] == `SLAVE_ADDR);
    u_amp_host_model.start_cond();
    u_amp_host_model.send_byte(addr, ack);
    check(ack, hit);
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? c1 : (i == 1) ? c2 : ~c1;
      u_amp_host_model.send_byte(b, ack);
      check(ack, hit);
    end
    u_amp_host_model.stop_cond();
    if (hit && n >= 2) begin
      app1 = c1;
      app2 = c2;
    end
    gap(40);
    check({ctl1, ctl2}, {app1[6:0], app2[6:0]});
  endtask : wr

  // host acks every byte but the last; a restart pulse must follow each read
  task automatic rd(input int n, input logic [31:0] e, input logic chk);
    u_amp_host_model.start_cond();
    u_amp_host_model.send_byte({`SLAVE_ADDR, 1'b1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_amp_host_model.recv_byte(i < n - 1, q);
      if (chk) check(q, e[31 - 8 * (i % 4) -: 8]);
    end
    u_amp_host_model.stop_cond();
    gap(40);
    exp_rst++;
    check(n_rst, exp_rst);
  endtask : rd

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    finish_test();
  end

  initial begin
    // reset needs a real edge at time zero: the bus-clocked flops see no clock in reset
    i_rst <= 1'b1;
    // faults present from time zero so the first full interval sees them steady
    f0 = 24'($random(seed));
    fault = f0;
    thermal = 1'b1;
    app1 = 8'h00;
    app2 = 8'h00;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    check({ctl1, ctl2, restart, sda_out}, 16'h0000);
    gap(3);
    for (int k = 0; k < 6; k++) begin
      c1 = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      c2 = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      wr({`SLAVE_ADDR, 1'b0}, (k == 5) ? 3 : 2);
    end
    $display("test control writes done");
    for (int k = 0; k < 4; k++) begin
      a = 8'($random(seed));
      if (a[7:1] == `SLAVE_ADDR) a[7] = ~a[7];
      c1 = ~app1;
      c2 = ~app2;
      wr(a, 2);
    end
    $display("test foreign address done");
    // power-up: operate with diagnostics, then unmute, then read
    c1 = 8'h60;
    c2 = 8'h14;
    wr({`SLAVE_ADDR, 1'b0}, 2);
    c1 = 8'h66;
    wr({`SLAVE_ADDR, 1'b0}, 2);
    rd(4, exp_status(1'b0, 1'b0, 24'h00_0000), 1'b1);
    rd(4, 32'h0000_0000, 1'b0);
    rd(5, exp_status(1'b1, 1'b1, f0), 1'b1);
    @(posedge i_clk);
    fault <= 24'h00_0000;
    thermal <= 1'b0;
    // cleared fault still shows once, then disappears
    rd(4, exp_status(1'b1, 1'b1, f0), 1'b1);
    rd(4, exp_status(1'b0, 1'b1, 24'h00_0000), 1'b1);
    $display("test read latency done");
    f2 = 24'($random(seed));
    m = 24'($random(seed));
    @(posedge i_clk);
    fault <= f2;
    thermal <= 1'b1;
    rd(2, exp_status(1'b0, 1'b1, 24'h00_0000), 1'b1);
    gap(10);
    fault <= f2 & ~m;
    @(posedge i_clk);
    fault <= f2;
    rd(4, exp_status(1'b0, 1'b1, 24'h00_0000), 1'b1);
    // one-cycle dropout removes those faults from the report
    rd(4, exp_status(1'b1, 1'b1, f2 & ~m), 1'b1);
    $display("test persistence done");
    // offset test, then current test: enable, wait, read until the flag clears
    for (int t = 0; t < 2; t++) begin
      m = t ? 24'h82_0820 : 24'h10_4104;
      fault <= m;
      c1 = t ? app1 & 8'hdf : app1 | 8'h20;
      c2 = t ? app2 | 8'h04 : app2 & 8'hfb;
      wr({`SLAVE_ADDR, 1'b0}, 2);
      rd(4, 32'h0000_0000, 1'b0);
      rd(4, 32'h0000_0000, 1'b0);
      rd(4, exp_status(1'b1, 1'b1, m), 1'b1);
      fault <= 24'h00_0000;
      rd(4, exp_status(1'b1, 1'b1, m), 1'b1);
      rd(4, exp_status(1'b1, 1'b1, 24'h00_0000), 1'b1);
    end
    $display("test offset and current done");
    // power-down: mute, then standby with diagnostics off
    c1 = app1 & 8'hf9;
    c2 = app2;
    wr({`SLAVE_ADDR, 1'b0}, 2);
    c1 = c1 & 8'hbf;
    c2 = c2 & 8'hef;
    wr({`SLAVE_ADDR, 1'b0}, 2);
    $display("test power-down done");
    finish_test();
  end
endmodule : amp_i2c_control_diag_tb
